// *** design/fastening_status_outputs.sv ***
`timescale 1ns/1ps
module fastening_status_outputs
  import fastening_pkg::*;
#(
  parameter int unsigned MS_CYC    = MS_CYCLES,
  parameter int unsigned GAP_CYC   = START_GAP_CYC,
  parameter int unsigned RETRY_LEN = RETRY_CYC
)
(
  input  wire  logic                 mclk,
  input  wire  logic                 rst_n,
  input  wire  logic                 psel,
  input  wire  logic                 penable,
  input  wire  logic                 pwrite,
  input  wire  logic [7:0]           paddr,
  input  wire  logic [31:0]          pwdata,
  output logic       [31:0]          prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire  logic                 start_pin,
  input  wire  logic                 run_pin,
  input  wire  logic                 reverse_pin,
  input  wire  logic                 reset_pin,
  input  wire  logic                 select_pin,
  input  wire  logic                 job_active,
  input  wire  logic [STEP_W-1:0]    job_step,
  input  wire  logic                 start_torque_seen,
  input  wire  logic                 target_reached,
  input  wire  logic                 abort_event,
  input  wire  logic                 fasten_complete,
  input  wire  logic                 fasten_ok,
  input  wire  logic                 pos_out_of_tol,
  input  wire  logic                 dend_done,
  input  wire  logic                 backoff_ng_event,
  input  wire  logic                 calendar_invalid,
  input  wire  logic [47:0]          calendar_now,
  input  wire  logic                 job_forced,
  input  wire  logic                 job_incomplete,
  input  wire  logic                 job_unsupported,
  input  wire  logic                 teach_mode,
  input  wire  logic                 teach_complete,
  input  wire  logic                 tracker_ok,
  input  wire  logic                 tracker_error,
  input  wire  logic                 tracker_link_up,
  input  wire  logic                 origin_done,
  input  wire  logic                 send_done,
  input  wire  logic                 send_fault,
  output logic                       ready,
  output logic                       run_permit,
  output logic                       cycle_done,
  output logic                       judge_ok,
  output logic                       judge_ng,
  output logic                       send_request,
  output logic       [STEP_W-1:0]    job_step_out,
  output logic                       loosen_done_flag,
  output logic                       under_target_flag,
  output logic                       trigger_release_flag,
  output logic                       tool_cycle_alarm,
  output logic                       backoff_angle_fail,
  output logic                       timekeeper_alarm,
  output logic                       teach_active,
  output logic                       teach_done,
  output logic                       tracker_ready,
  output logic                       place_fail,
  output logic                       homing_done,
  output logic                       heartbeat_toggle,
  output logic                       one_second_toggle,
  output logic       [NUM_COILS-1:0] ladder_coils
);

  logic [PIN_W-1:0]     pin_raw;
  logic [PIN_W-1:0]     pin_meta;
  logic [PIN_W-1:0]     pin_s;
  logic [PIN_W-1:0]     pin_d;
  logic [CTL_W-1:0]     ctrl;
  logic [31:0]          cyc_limit;
  logic [31:0]          cyc_count;
  logic [31:0]          run_dur;
  logic [31:0]          all_dur;
  logic [31:0]          ms_cnt;
  logic [15:0]          half_ms;
  logic                 ms_tick;
  logic [31:0]          gap_cnt;
  logic [31:0]          retry_cnt;
  logic [127:0]         coil_words;
  cycle_state_t         state;
  logic                 reversing;
  logic                 target_seen;
  logic                 ext_selected;
  logic [2:0]           verdict;
  logic [47:0]          stamp;
  logic                 clear_evt;
  logic                 start_rise;
  logic                 start_ok;
  logic                 wr_en;
  logic                 rd_setup;
  logic                 blocked;
  logic                 abort_now;
  logic                 rel_abort;
  logic                 src_ext;
  logic [31:0]          status_word;
  logic [31:0]          next_rdata;
  logic                 next_err;
  program_source_t      src_sel;
  table_sel_t           tbl_sel;

  assign pin_raw = {select_pin, reset_pin, reverse_pin, run_pin, start_pin};

  // the first stage is read by the second stage only
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_meta <= '0;
      pin_s    <= '0;
      pin_d    <= '0;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
      pin_d    <= pin_s;
    end
  end

  assign start_rise = pin_s[PIN_START] & ~pin_d[PIN_START];
  assign clear_evt  = start_rise
                    | (pin_s[PIN_RUN] & ~pin_d[PIN_RUN])
                    | (pin_s[PIN_RST] & ~pin_d[PIN_RST]);
  assign src_sel    = program_source_t'(ctrl[CTL_SRC_LSB +: 3]);
  assign tbl_sel    = table_sel_t'(ctrl[CTL_TBL_LSB +: 2]);
  assign src_ext    = (src_sel == SRC_CH_EXT) || (src_sel == SRC_JOB_EXT);
  assign blocked    = (state == ST_SEND) || (retry_cnt != '0);
  // a start inside the rest gap is simply not taken
  assign start_ok   = start_rise && (gap_cnt == '0) && !blocked
                    && (state == ST_IDLE) && (!src_ext || ext_selected);
  assign abort_now  = (state == ST_RUN) && !reversing && !fasten_complete
                    && (abort_event || !pin_s[PIN_START]);
  assign rel_abort  = !pin_s[PIN_START] && !abort_event;

  // one tick chain: millisecond prescale, then half-second count
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ms_cnt            <= '0;
      ms_tick           <= 1'b0;
      half_ms           <= '0;
      heartbeat_toggle  <= 1'b0;
      one_second_toggle <= 1'b0;
    end
    else
    begin
      ms_tick <= 1'b0;
      if (ms_cnt == MS_CYC - 1)
      begin
        ms_cnt  <= '0;
        ms_tick <= 1'b1;
      end
      else
        ms_cnt <= ms_cnt + 32'h0000_0001;
      if (ms_tick)
      begin
        if (half_ms == 16'(HALF_SEC_MS - 1))
        begin
          half_ms          <= '0;
          heartbeat_toggle <= ~heartbeat_toggle;
          if (heartbeat_toggle)
            one_second_toggle <= ~one_second_toggle;
        end
        else
          half_ms <= half_ms + 16'h0001;
      end
    end
  end

  // start rest gap and retransmission block
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      gap_cnt   <= '0;
      retry_cnt <= '0;
    end
    else
    begin
      if (!pin_s[PIN_START] && pin_d[PIN_START])
        gap_cnt <= GAP_CYC;
      else if (gap_cnt != '0)
        gap_cnt <= gap_cnt - 32'h0000_0001;
      if (send_fault)
        retry_cnt <= RETRY_LEN;
      else if (retry_cnt != '0)
        retry_cnt <= retry_cnt - 32'h0000_0001;
    end
  end

  // fastening cycle sequence
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state        <= ST_IDLE;
      reversing    <= 1'b0;
      judge_ok     <= 1'b0;
      judge_ng     <= 1'b0;
      cycle_done   <= 1'b0;
      send_request <= 1'b0;
      verdict      <= VERDICT_OK;
      stamp        <= '0;
    end
    else
    begin
      send_request <= 1'b0;
      unique case (state)
        ST_IDLE:
          if (start_ok)
          begin
            state      <= ST_RUN;
            reversing  <= pin_s[PIN_REV];
            judge_ok   <= 1'b0;
            judge_ng   <= 1'b0;
            cycle_done <= 1'b0;
          end
        ST_RUN:
          if (reversing)
          begin
            if (!pin_s[PIN_START])
              state <= ST_IDLE;
          end
          else if (fasten_complete)
          begin
            state <= ST_DEND;
            stamp <= calendar_now;
          end
          else if (abort_now)
          begin
            state    <= ST_IDLE;
            judge_ng <= 1'b1;
          end
        ST_DEND:
          if (dend_done)
          begin
            // verdicts go out before any completion signal
            judge_ok <= fasten_ok;
            judge_ng <= ~fasten_ok;
            if (job_unsupported)
              verdict <= VERDICT_UNSUPPORTED;
            else if (job_incomplete)
              verdict <= VERDICT_INCOMPLETE;
            else if (job_forced)
              verdict <= VERDICT_FORCED;
            else if (fasten_ok)
              verdict <= VERDICT_OK;
            else
              verdict <= VERDICT_NG;
            if (ctrl[CTL_SEND_EN])
            begin
              state        <= ST_SEND;
              send_request <= 1'b1;
            end
            else
              state <= ST_DONE;
          end
        ST_SEND:
          if (send_done)
            state <= ST_DONE;
        ST_DONE:
        begin
          cycle_done <= 1'b1;
          if (start_rise)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // durations in milliseconds; overall keeps counting through delayed end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      run_dur <= '0;
      all_dur <= '0;
    end
    else if (start_ok)
    begin
      run_dur <= '0;
      all_dur <= '0;
    end
    else if (ms_tick && !reversing)
    begin
      if (state == ST_RUN)
        run_dur <= run_dur + 32'h0000_0001;
      if (state == ST_RUN || state == ST_DEND)
        all_dur <= all_dur + 32'h0000_0001;
    end
  end

  // external selection must be seen before ready in external modes
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ext_selected <= 1'b0;
    else if (pin_s[PIN_SEL])
      ext_selected <= 1'b1;
    else if (state == ST_DONE && start_rise)
      ext_selected <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ready      <= 1'b0;
      run_permit <= 1'b0;
    end
    else
    begin
      ready      <= (state == ST_IDLE) && !blocked
                  && (!src_ext || ext_selected);
      run_permit <= !blocked;
    end
  end

  // latched fault flags: a set in the clearing cycle wins, except target_seen, where start_ok clears it
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      target_seen          <= 1'b0;
      loosen_done_flag     <= 1'b0;
      under_target_flag    <= 1'b0;
      trigger_release_flag <= 1'b0;
      backoff_angle_fail   <= 1'b0;
      place_fail           <= 1'b0;
      homing_done          <= 1'b0;
    end
    else
    begin
      if (start_ok)
        target_seen <= 1'b0;
      else if (target_reached)
        target_seen <= 1'b1;
      if (state == ST_RUN && reversing && start_torque_seen)
        loosen_done_flag <= 1'b1;
      else if (start_rise)
        loosen_done_flag <= 1'b0;
      if (abort_now && ctrl[CTL_UNDER_EN] && !target_seen
          && !target_reached)
        under_target_flag <= 1'b1;
      else if (clear_evt)
        under_target_flag <= 1'b0;
      if (abort_now && rel_abort && ctrl[CTL_TRIG_EN])
        trigger_release_flag <= 1'b1;
      else if (clear_evt)
        trigger_release_flag <= 1'b0;
      if (backoff_ng_event)
        backoff_angle_fail <= 1'b1;
      else if (clear_evt)
        backoff_angle_fail <= 1'b0;
      if (state == ST_RUN && !reversing && fasten_complete
          && ctrl[CTL_POS_EN] && pos_out_of_tol)
        place_fail <= 1'b1;
      else if (clear_evt)
        place_fail <= 1'b0;
      if (origin_done && (tbl_sel == TBL_XY || tbl_sel == TBL_XYZ))
        homing_done <= 1'b1;
      else if (pin_s[PIN_RST] && !pin_d[PIN_RST])
        homing_done <= 1'b0;
    end
  end

  // level status outputs
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      job_step_out     <= '0;
      timekeeper_alarm <= 1'b0;
      teach_active     <= 1'b0;
      teach_done       <= 1'b0;
      tracker_ready    <= 1'b0;
      tool_cycle_alarm <= 1'b0;
    end
    else
    begin
      job_step_out     <= job_active ? job_step : '0;
      timekeeper_alarm <= calendar_invalid;
      teach_active     <= teach_mode;
      if (teach_mode && teach_complete)
        teach_done <= 1'b1;
      else if (!teach_mode)
        teach_done <= 1'b0;
      tracker_ready <= tracker_ok && tracker_link_up
                     && !tracker_error;
      tool_cycle_alarm <= cyc_count > cyc_limit;
    end
  end

  // tool cycle counter; a software write clears it unless a start is counted in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cyc_count <= '0;
    else if (start_ok && cyc_count != 32'hFFFF_FFFF)
      cyc_count <= cyc_count + 32'h0000_0001;
    else if (wr_en && paddr == REG_CYC_COUNT)
      cyc_count <= '0;
  end

  // apb slave: zero wait states, answer registered in setup
  assign wr_en    = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl       <= CTL_RESET;
      cyc_limit  <= '0;
      coil_words <= '0;
    end
    else if (wr_en && !pslverr)
    begin
      if (paddr == REG_CTRL)
        ctrl <= pwdata[CTL_W-1:0];
      if (paddr == REG_CYC_LIMIT)
        cyc_limit <= pwdata;
      for (int i = 0; i < COIL_WORDS; i++)
        if (paddr == REG_COIL0 + 8'(4 * i))
          coil_words[32*i +: 32] <= pwdata;
    end
  end

  // coils beyond the implemented count read back as zero
  genvar g;
  generate
    for (g = 0; g < NUM_COILS; g++)
    begin : g_coil
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
          ladder_coils[g] <= 1'b0;
        else
          ladder_coils[g] <= coil_words[g];
      end
    end
  endgenerate

  assign status_word = {16'h0000, 3'h0, ext_selected, blocked, state,
                        homing_done, place_fail, backoff_angle_fail,
                        trigger_release_flag, under_target_flag,
                        loosen_done_flag, tool_cycle_alarm,
                        cycle_done};

  always_comb
  begin
    next_rdata = '0;
    next_err   = 1'b0;
    case (paddr)
      REG_CTRL:      next_rdata = {23'h000000, ctrl};
      REG_CYC_LIMIT: next_rdata = cyc_limit;
      REG_STATUS:    next_rdata = status_word;
      REG_CYC_COUNT: next_rdata = cyc_count;
      REG_COIL0:     next_rdata = coil_words[31:0];
      REG_COIL1:     next_rdata = coil_words[63:32];
      REG_COIL2:     next_rdata = coil_words[95:64];
      REG_COIL3:     next_rdata = {29'h0, coil_words[98:96]};
      REG_RUN_DUR:   next_rdata = run_dur;
      REG_ALL_DUR:   next_rdata = all_dur;
      REG_VERDICT:   next_rdata = {29'h0, verdict};
      REG_STAMP_HI:  next_rdata = {8'h00, stamp[47:24]};
      REG_STAMP_LO:  next_rdata = {8'h00, stamp[23:0]};
      default:       next_err   = 1'b1;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_setup;
      if (rd_setup)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err || (pwrite && (paddr == REG_STATUS
                   || paddr == REG_RUN_DUR || paddr == REG_ALL_DUR
                   || paddr == REG_VERDICT || paddr == REG_STAMP_HI
                   || paddr == REG_STAMP_LO));
      end
      else
        pslverr <= 1'b0;
    end
  end

endmodule

// *** design/fastening_pkg.sv ***
package fastening_pkg;

  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned MS_CYCLES      = CLK_HZ / MS_PER_S;
  localparam int unsigned HALF_SEC_MS    = 500;
  localparam int unsigned START_GAP_MS   = 200;
  localparam int unsigned RETRY_BLOCK_MS = 2000;
  localparam int unsigned START_GAP_CYC  = START_GAP_MS * MS_CYCLES;
  localparam int unsigned RETRY_CYC      = RETRY_BLOCK_MS * MS_CYCLES;

  localparam int unsigned NUM_COILS = 99;
  localparam int unsigned STEP_W    = 6;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_CYC_LIMIT = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_CYC_COUNT = 8'h0C;
  localparam logic [7:0] REG_COIL0     = 8'h10;
  localparam logic [7:0] REG_COIL1     = 8'h14;
  localparam logic [7:0] REG_COIL2     = 8'h18;
  localparam logic [7:0] REG_COIL3     = 8'h1C;
  localparam logic [7:0] REG_RUN_DUR   = 8'h20;
  localparam logic [7:0] REG_ALL_DUR   = 8'h24;
  localparam logic [7:0] REG_VERDICT   = 8'h28;
  localparam logic [7:0] REG_STAMP_HI  = 8'h2C;
  localparam logic [7:0] REG_STAMP_LO  = 8'h30;
  localparam int unsigned COIL_WORDS   = 4;

  // control register fields
  localparam int unsigned CTL_UNDER_EN = 0;
  localparam int unsigned CTL_TRIG_EN  = 1;
  localparam int unsigned CTL_POS_EN   = 2;
  localparam int unsigned CTL_SEND_EN  = 3;
  localparam int unsigned CTL_SRC_LSB  = 4;
  localparam int unsigned CTL_TBL_LSB  = 7;
  localparam int unsigned CTL_W        = 9;
  localparam logic [CTL_W-1:0] CTL_RESET = 9'h000;

  typedef enum logic [2:0]
  {
    SRC_CH_INT  = 3'h0,
    SRC_CH_EXT  = 3'h1,
    SRC_JOB_INT = 3'h2,
    SRC_JOB_EXT = 3'h3,
    SRC_ID      = 3'h4
  } program_source_t;

  typedef enum logic [1:0]
  {
    TBL_NONE = 2'h0,
    TBL_XY   = 2'h1,
    TBL_XYZ  = 2'h2
  } table_sel_t;

  typedef enum logic [2:0]
  {
    VERDICT_OK          = 3'h0,
    VERDICT_NG          = 3'h1,
    VERDICT_FORCED      = 3'h2,
    VERDICT_INCOMPLETE  = 3'h3,
    VERDICT_UNSUPPORTED = 3'h4
  } job_verdict_t;

  // gray sequence from ST_IDLE through ST_SEND to ST_DONE
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_RUN  = 3'b001,
    ST_DEND = 3'b011,
    ST_SEND = 3'b010,
    ST_DONE = 3'b110
  } cycle_state_t;

  // synchronised pin positions
  localparam int unsigned PIN_START = 0;
  localparam int unsigned PIN_RUN   = 1;
  localparam int unsigned PIN_REV   = 2;
  localparam int unsigned PIN_RST   = 3;
  localparam int unsigned PIN_SEL   = 4;
  localparam int unsigned PIN_W     = 5;

endpackage

// *** test/fastening_sva.sv ***
`timescale 1ns/1ps
module fastening_sva
  import fastening_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
)
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              job_active,
  input wire logic [STEP_W-1:0] job_step,
  input wire logic [STEP_W-1:0] job_step_out,
  input wire logic              teach_mode,
  input wire logic              teach_done,
  input wire logic              tracker_error,
  input wire logic              tracker_link_up,
  input wire logic              tracker_ready,
  input wire logic              calendar_invalid,
  input wire logic              timekeeper_alarm,
  input wire logic              heartbeat_toggle,
  input wire logic              one_second_toggle,
  input wire logic              send_request,
  input wire logic              send_done,
  input wire logic              cycle_done,
  input wire logic              judge_ok,
  input wire logic              judge_ng
);
  localparam int unsigned HALF = HALF_SEC_MS * MS_CYC;
  localparam int unsigned FULL = 2 * HALF;
  int unsigned hb_cnt;
  int unsigned sec_cnt;
  logic        sending;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // windows allow two cycles of slack for the first period after reset
  always_ff @(posedge mclk)
    if (!rst_n || $changed(heartbeat_toggle))
      hb_cnt <= 0;
    else
      hb_cnt <= hb_cnt + 1;
  always_ff @(posedge mclk)
    if (!rst_n || $changed(one_second_toggle))
      sec_cnt <= 0;
    else
      sec_cnt <= sec_cnt + 1;
  always_ff @(posedge mclk)
    if (!rst_n || send_done)
      sending <= 1'b0;
    else if (send_request)
      sending <= 1'b1;
  a_step_follow: assert property (
    1'b1 |=> job_step_out == ($past(job_active) ? $past(job_step) : 6'h00))
    else $error("step outputs wrong");
  a_teach_end: assert property (!teach_mode |=> !teach_done)
    else $error("teach done outside teach mode");
  a_tracker_off: assert property (
    (tracker_error || !tracker_link_up) |=> !tracker_ready)
    else $error("tracker ready while faulted");
  a_clock_alarm: assert property (calendar_invalid |=> timekeeper_alarm)
    else $error("calendar alarm missing");
  a_beat_period: assert property (
    hb_cnt + 2 >= HALF && hb_cnt <= HALF + 1 || !$changed(heartbeat_toggle))
    else $error("heartbeat period wrong");
  a_second_period: assert property (
    sec_cnt + 2 >= FULL && sec_cnt <= FULL + 1 || !$changed(one_second_toggle))
    else $error("second toggle period wrong");
  a_done_judged: assert property (
    $rose(cycle_done) |-> (judge_ok || judge_ng) && !sending)
    else $error("cycle done before verdict or send");
  a_send_hold: assert property (sending |-> !cycle_done)
    else $error("cycle done while sending");
endmodule

// *** test/plc_model.sv ***
`timescale 1ns/1ps
module plc_model
#(
  parameter int GAP  = 30,
  parameter int LEAD = 1000
)
(
  input wire logic mclk,
  input wire logic cmd_start,
  input wire logic cmd_rev,
  output logic     start_pin,
  output logic     reverse_pin
);
  int idle;
  // spacing is kept here so no scenario can break it by accident
  initial
  begin
    start_pin = 1'b0;
    reverse_pin = 1'b0;
    idle = GAP;
    forever
    begin
      @(posedge mclk);
      idle = start_pin ? 0 : idle + 1;
      if (!cmd_start)
      begin
        start_pin <= 1'b0;
        reverse_pin <= 1'b0;
      end
      else if (!start_pin)
      begin
        reverse_pin <= cmd_rev;
        if (cmd_rev)
          repeat (LEAD) @(posedge mclk);
        while (idle < GAP)
        begin
          @(posedge mclk);
          idle++;
        end
        start_pin <= 1'b1;
      end
    end
  end
endmodule

// *** test/test_fastening_status_outputs.sv ***
`timescale 1ns/1ps
module test_fastening_status_outputs;
  import fastening_pkg::*;
  localparam int unsigned MSC = 10;
  logic                 mclk = 1'b0;
  logic                 rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 start_pin, run_pin, reverse_pin, reset_pin;
  logic                 select_pin, job_active, start_torque_seen;
  logic                 target_reached, abort_event, fasten_complete;
  logic                 fasten_ok, pos_out_of_tol, dend_done, send_fault;
  logic                 backoff_ng_event, calendar_invalid, job_forced;
  logic                 job_incomplete, job_unsupported, teach_mode;
  logic                 teach_complete, tracker_ok, tracker_error;
  logic                 tracker_link_up, origin_done, send_done, cmd_rev;
  logic                 ready, run_permit, cycle_done, judge_ok, judge_ng;
  logic                 send_request, loosen_done_flag, under_target_flag;
  logic                 trigger_release_flag, tool_cycle_alarm, teach_done;
  logic                 backoff_angle_fail, timekeeper_alarm, teach_active;
  logic                 tracker_ready, place_fail, homing_done, cmd_start;
  logic                 heartbeat_toggle, one_second_toggle;
  logic [STEP_W-1:0]    job_step, job_step_out;
  logic [47:0]          calendar_now;
  logic [NUM_COILS-1:0] ladder_coils;
  int                   fail_count, compares;

  fastening_status_outputs #(.MS_CYC(MSC), .GAP_CYC(20), .RETRY_LEN(30))
    dut (.*);
  plc_model #(.LEAD(100 * MSC)) plc (.*);

  always #10 mclk = ~mclk;

  task automatic stop_test;
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected %0t got %h want %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic wait_sig(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (s !== v && n < lim);
    if (s !== v)
    begin
      $display("unexpected %0t wait ran out", $time);
      fail_count++;
      stop_test();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    wait_sig(pready, 1'b1, 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never rewrites psel at once
    @(posedge mclk);
  endtask

  task automatic s_levels;
    job_active <= 1'b1;
    job_step <= 6'h2A;
    {teach_mode, calendar_invalid, tracker_ok, tracker_link_up} <= 4'hF;
    tick(3);
    chk(job_step_out, 32'h2A);
    chk(teach_active, 1'b1);
    chk(timekeeper_alarm, 1'b1);
    chk(tracker_ready, 1'b1);
    teach_complete <= 1'b1;
    tick(1);
    teach_complete <= 1'b0;
    tick(2);
    chk(teach_done, 1'b1);
    {job_active, teach_mode, calendar_invalid, tracker_error} <= 4'h1;
    backoff_ng_event <= 1'b1;
    tick(1);
    backoff_ng_event <= 1'b0;
    tick(2);
    chk(job_step_out, 32'h0);
    chk(tracker_ready, 1'b0);
    chk(backoff_angle_fail, 1'b1);
    run_pin <= 1'b1;
    tick(5);
    chk(backoff_angle_fail, 1'b0);
    run_pin <= 1'b0;
  endtask

  task automatic s_cycle;
    apb(1'b1, REG_CYC_LIMIT, 32'h0);
    apb(1'b1, REG_CTRL, 32'h0000000C);
    apb(1'b0, 8'h3C, 32'h0);
    chk(err, 1'b1);
    calendar_now <= 48'h0C051E0A142D;
    job_forced <= 1'b1;
    {pos_out_of_tol, target_reached, fasten_ok, cmd_start} <= 4'hF;
    tick(8);
    fasten_complete <= 1'b1;
    tick(1);
    fasten_complete <= 1'b0;
    tick(2);
    chk(place_fail, 1'b1);
    dend_done <= 1'b1;
    tick(1);
    dend_done <= 1'b0;
    wait_sig(send_request, 1'b1, 10);
    tick(4);
    chk(cycle_done, 1'b0);
    chk(ready, 1'b0);
    chk(run_permit, 1'b0);
    send_done <= 1'b1;
    tick(1);
    send_done <= 1'b0;
    wait_sig(cycle_done, 1'b1, 10);
    tick(2);
    chk(judge_ok, 1'b1);
    chk(tool_cycle_alarm, 1'b1);
    apb(1'b0, REG_STAMP_HI, 32'h0);
    chk(rd, 32'h000C051E);
    apb(1'b0, REG_VERDICT, 32'h0);
    chk(rd, VERDICT_FORCED);
    {job_forced, pos_out_of_tol, target_reached, cmd_start} <= 4'h0;
  endtask

  task automatic s_abort;
    apb(1'b1, REG_CTRL, 32'h3);
    // first start only leaves the done state; ready shows idle
    cmd_start <= 1'b1;
    wait_sig(ready, 1'b1, 100);
    cmd_start <= 1'b0;
    tick(1);
    cmd_start <= 1'b1;
    wait_sig(ready, 1'b0, 100);
    chk(place_fail, 1'b0);
    cmd_start <= 1'b0;
    tick(8);
    chk(trigger_release_flag, 1'b1);
    chk(under_target_flag, 1'b1);
    cmd_start <= 1'b1;
    tick(50);
    chk(under_target_flag, 1'b0);
    cmd_start <= 1'b0;
  endtask

  task automatic s_reverse;
    // the model must see start low before it leads with reverse
    tick(1);
    {cmd_rev, cmd_start} <= 2'h3;
    tick(100 * MSC + 40);
    start_torque_seen <= 1'b1;
    tick(1);
    start_torque_seen <= 1'b0;
    tick(2);
    chk(loosen_done_flag, 1'b1);
    {cmd_rev, cmd_start} <= 2'h0;
  endtask

  task automatic s_ext;
    apb(1'b1, REG_CTRL, 32'h90);
    tick(30);
    chk(ready, 1'b0);
    select_pin <= 1'b1;
    tick(6);
    chk(ready, 1'b1);
    select_pin <= 1'b0;
    origin_done <= 1'b1;
    tick(1);
    origin_done <= 1'b0;
    tick(2);
    chk(homing_done, 1'b1);
    reset_pin <= 1'b1;
    tick(5);
    chk(homing_done, 1'b0);
    reset_pin <= 1'b0;
    apb(1'b1, REG_COIL0, 32'hA5C3_0F96);
    tick(1);
    chk(ladder_coils[31:0], 32'hA5C3_0F96);
    send_fault <= 1'b1;
    tick(1);
    send_fault <= 1'b0;
    tick(2);
    chk(run_permit, 1'b0);
    tick(35);
    chk(run_permit, 1'b1);
  endtask

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, cmd_start, cmd_rev} = '0;
    {run_pin, reset_pin, select_pin, job_active, job_step} = '0;
    {start_torque_seen, target_reached, abort_event, fasten_complete} = '0;
    {fasten_ok, pos_out_of_tol, dend_done, backoff_ng_event} = '0;
    {calendar_invalid, job_forced, job_incomplete, job_unsupported} = '0;
    {teach_mode, teach_complete, tracker_ok, tracker_error} = '0;
    {tracker_link_up, origin_done, send_done, send_fault} = '0;
    calendar_now = '0;
    fail_count = 0;
    compares = 0;
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    s_levels();
    s_cycle();
    s_abort();
    s_reverse();
    s_ext();
    wait_sig(heartbeat_toggle, !heartbeat_toggle, 500 * MSC + 5);
    wait_sig(one_second_toggle, !one_second_toggle, 1000 * MSC + 5);
    stop_test();
  end
endmodule

bind fastening_status_outputs fastening_sva #(.MS_CYC(MS_CYC)) u_sva (.*);
